// [hw/srl_div_if.sv]
// Link between the latch control and its clock divider
`timescale 1ns/1ns
`default_nettype none
interface srl_div_if;
   srl_pkg::srl_div_sel_t sel;
   logic pulse;
   modport ctrl (output sel, input pulse);
   modport div (input sel, output pulse);
endinterface : srl_div_if
`default_nettype wire

// [hw/srl_divider.sv]
// Programmable divider giving a one-cycle pulse every 4 to 512 cycles
`timescale 1ns/1ns
`default_nettype none
`include "srl_latch_cfg.svh"
module srl_divider (
   input wire logic clk_i,
   input wire logic rst_i,
   srl_div_if.div dv
);
   srl_pkg::srl_div_cnt_t cnt_r;
   srl_pkg::srl_div_cnt_t term;
   logic pulse_r;

   function automatic srl_pkg::srl_div_cnt_t div_last(
      input srl_pkg::srl_div_sel_t s);
      div_last = srl_pkg::srl_div_cnt_t'((`SRL_DIV_BASE << s) - 10'h001);
   endfunction : div_last

   assign term = div_last(dv.sel);

   // Period count
   // Compare with >= so a shorter select never strands the count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 10'h000;
      end else if (cnt_r >= term) begin
         cnt_r <= 10'h000;
      end else begin
         cnt_r <= cnt_r + 10'h001;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= (cnt_r >= term);
      end
   end

   assign dv.pulse = pulse_r;
endmodule : srl_divider
`default_nettype wire

// [hw/srl_latch_cfg.svh]
// Offsets, field positions, reset values and timing counts of the latch
// How it works
// - True and complement outputs may both drive pins, each own enable.
// - Reset leaves latch state undefined; firmware sets it before outputs.
// - Divider emits one-cycle pulse every 4..512 cycles per select code.
// - Module enable bit 1 enables; when 0 no output reaches a pin.
// - Enabled and true enable set: true latch output drives its pin.
// - Enabled and complement enable set: complement output drives pin.
// - Writing 1 to software set pulses set input one cycle.
// - Writing 1 to software reset pulses reset input one cycle.
// - Software set and reset bits always read back as zero.
// - Pin set enable: latch sets while external input pin high.
// - Clock set enable: each divider pulse pulses the set input.
// - Comparator set enable: latch sets while comparator output high.
// - Pin reset enable: latch resets while external input pin high.
// - Clock reset enable: each divider pulse pulses the reset input.
// - Comparator reset enable: latch resets while comparator high.
// - Reserved source-select bits read zero; software writes them zero.
// - Latch is reset-dominant when set and reset both asserted.
`ifndef SRL_LATCH_CFG_SVH
`define SRL_LATCH_CFG_SVH

`define SRL_OFS_MAIN 12'h000
`define SRL_OFS_SRC 12'h004
`define SRL_OFS_STAT 12'h008

`define SRL_MAIN_RST 8'h00
`define SRL_SRC_RST 8'h00
`define SRL_SRC_WMASK 8'hDD

`define SRL_B_MOD_EN 7
`define SRL_B_DIV_HI 6
`define SRL_B_DIV_LO 4
`define SRL_B_TRUE_EN 3
`define SRL_B_COMP_EN 2
`define SRL_B_SW_SET 1
`define SRL_B_SW_RST 0

`define SRL_B_PIN_SET 7
`define SRL_B_CLK_SET 6
`define SRL_B_CMP_SET 4
`define SRL_B_PIN_RST 3
`define SRL_B_CLK_RST 2
`define SRL_B_CMP_RST 0

`define SRL_B_ST_LATCH 0
`define SRL_B_ST_DIV 1

`define SRL_DIV_BASE 10'h004
`define SRL_DIV_W 10

`endif

// [hw/srl_latch_ctrl.sv]
// Set/reset latch control with APB register access
`timescale 1ns/1ns
`default_nettype none
`include "srl_latch_cfg.svh"
module srl_latch_ctrl (
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic EXTERNAL_SETRESET_INPUT_I,
   input wire logic FIRST_COMPARATOR_I,
   output logic TRUE_OUTPUT_PIN_O,
   output logic TRUE_OUTPUT_PIN_OE_N_O,
   output logic COMPLEMENT_OUTPUT_PIN_O,
   output logic COMPLEMENT_OUTPUT_PIN_OE_N_O
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   srl_pkg::srl_byte_t main_r;
   srl_pkg::srl_byte_t src_r;
   logic sw_set_r;
   logic sw_rst_r;
   logic pin_s1_r;
   logic pin_s2_r;
   logic cmp_s1_r;
   logic cmp_s2_r;
   logic latch_r;
   logic latch_nxt;
   logic set_comb;
   logic rst_comb;
   logic div_seen_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic true_pin_r;
   logic true_oe_n_r;
   logic comp_pin_r;
   logic comp_oe_n_r;
   logic apb_done;
   logic wr_main;
   logic wr_src;
   logic mapped;
   logic strb0;

   srl_div_if dif ();

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic addr_hit(
      input logic [11:0] a,
      input logic [11:0] ofs);
      addr_hit = (a == ofs);
   endfunction : addr_hit

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   // Access phase completes on the edge where pready is seen high
   assign apb_done = PSEL_I & PENABLE_I & pready_r;
   assign mapped = addr_hit(PADDR_I, `SRL_OFS_MAIN)
      | addr_hit(PADDR_I, `SRL_OFS_SRC)
      | addr_hit(PADDR_I, `SRL_OFS_STAT);
   // Only the low byte lane holds data
   assign strb0 = PSTRB_I[0];
   assign wr_main = apb_done & PWRITE_I & strb0
      & addr_hit(PADDR_I, `SRL_OFS_MAIN);
   assign wr_src = apb_done & PWRITE_I & strb0
      & addr_hit(PADDR_I, `SRL_OFS_SRC);

   // One wait state: ready rises in the second access cycle
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pready_r <= 1'b0;
      end else if (PSEL_I & PENABLE_I & ~pready_r) begin
         pready_r <= 1'b1;
      end else begin
         pready_r <= 1'b0;
      end
   end

   // Unmapped addresses answer with an error, no side effect
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pslverr_r <= 1'b0;
      end else if (PSEL_I & PENABLE_I & ~pready_r) begin
         pslverr_r <= ~mapped;
      end else begin
         pslverr_r <= 1'b0;
      end
   end

   // Read data is captured with ready
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         prdata_r <= 32'h0000_0000;
      end else if (PSEL_I & PENABLE_I & ~pready_r & ~PWRITE_I) begin
         prdata_r <= 32'h0000_0000;
         if (addr_hit(PADDR_I, `SRL_OFS_MAIN)) begin
            prdata_r[7:0] <= main_r & 8'hFC;
         end else if (addr_hit(PADDR_I, `SRL_OFS_SRC)) begin
            prdata_r[7:0] <= src_r & `SRL_SRC_WMASK;
         end else if (addr_hit(PADDR_I, `SRL_OFS_STAT)) begin
            // Latch bit is unknown until the first set or reset from any source
            prdata_r[`SRL_B_ST_LATCH] <= latch_r;
            prdata_r[`SRL_B_ST_DIV] <= div_seen_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         main_r <= `SRL_MAIN_RST;
      end else if (wr_main) begin
         main_r <= PWDATA_I[7:0] & 8'hFC;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         src_r <= `SRL_SRC_RST;
      end else if (wr_src) begin
         src_r <= PWDATA_I[7:0] & `SRL_SRC_WMASK;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sw_set_r <= 1'b0;
      end else begin
         sw_set_r <= wr_main & PWDATA_I[`SRL_B_SW_SET];
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sw_rst_r <= 1'b0;
      end else begin
         sw_rst_r <= wr_main & PWDATA_I[`SRL_B_SW_RST];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= EXTERNAL_SETRESET_INPUT_I;
         pin_s2_r <= pin_s1_r;
      end
   end

   // Comparator may change at any time relative to this clock
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
      end else begin
         cmp_s1_r <= FIRST_COMPARATOR_I;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider

   assign dif.sel = main_r[`SRL_B_DIV_HI:`SRL_B_DIV_LO];

   srl_divider u_div (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .dv(dif.div)
   );

   // Sticky indication that the divider has ticked since the last status read
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         div_seen_r <= 1'b0;
      end else if (dif.pulse) begin
         div_seen_r <= 1'b1;
      end else if (apb_done & ~PWRITE_I
            & addr_hit(PADDR_I, `SRL_OFS_STAT)) begin
         div_seen_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Latch core

   always_comb begin
      set_comb = sw_set_r;
      set_comb = set_comb | (src_r[`SRL_B_PIN_SET] & pin_s2_r);
      set_comb = set_comb | (src_r[`SRL_B_CLK_SET] & dif.pulse);
      set_comb = set_comb | (src_r[`SRL_B_CMP_SET] & cmp_s2_r);
   end

   always_comb begin
      rst_comb = sw_rst_r;
      rst_comb = rst_comb | (src_r[`SRL_B_PIN_RST] & pin_s2_r);
      rst_comb = rst_comb | (src_r[`SRL_B_CLK_RST] & dif.pulse);
      rst_comb = rst_comb | (src_r[`SRL_B_CMP_RST] & cmp_s2_r);
   end

   always_comb begin
      if (rst_comb) begin
         latch_nxt = 1'b0;
      end else if (set_comb) begin
         latch_nxt = 1'b1;
      end else begin
         latch_nxt = latch_r;
      end
   end

   // No reset term: state stays unknown until first set or reset
   always_ff @(posedge REF_CLK_I) begin
      latch_r <= latch_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pins

   // True pin gated by its own enable
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         true_pin_r <= 1'b0;
         true_oe_n_r <= 1'b1;
      end else if (main_r[`SRL_B_MOD_EN] & main_r[`SRL_B_TRUE_EN]) begin
         true_pin_r <= latch_nxt;
         true_oe_n_r <= 1'b0;
      end else begin
         true_pin_r <= 1'b0;
         true_oe_n_r <= 1'b1;
      end
   end

   // Complement pin gated by its own enable
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         comp_pin_r <= 1'b0;
         comp_oe_n_r <= 1'b1;
      end else if (main_r[`SRL_B_MOD_EN] & main_r[`SRL_B_COMP_EN]) begin
         comp_pin_r <= ~latch_nxt;
         comp_oe_n_r <= 1'b0;
      end else begin
         comp_pin_r <= 1'b0;
         comp_oe_n_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port drive

   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign TRUE_OUTPUT_PIN_O = true_pin_r;
   assign TRUE_OUTPUT_PIN_OE_N_O = true_oe_n_r;
   assign COMPLEMENT_OUTPUT_PIN_O = comp_pin_r;
   assign COMPLEMENT_OUTPUT_PIN_OE_N_O = comp_oe_n_r;

endmodule : srl_latch_ctrl
`default_nettype wire

// [hw/srl_pkg.sv]
// Types shared by the latch control files
package srl_pkg;
   typedef logic [7:0] srl_byte_t;
   typedef logic [2:0] srl_div_sel_t;
   typedef logic [9:0] srl_div_cnt_t;
endpackage : srl_pkg

// [verif/srl_latch_ctrl_checker.sv]
// Port-level assertions for the latch control block
`timescale 1ns/1ns
`default_nettype none
`include "srl_latch_cfg.svh"
module srl_latch_ctrl_checker (
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic TRUE_OUTPUT_PIN_O,
   input wire logic TRUE_OUTPUT_PIN_OE_N_O,
   input wire logic COMPLEMENT_OUTPUT_PIN_O,
   input wire logic COMPLEMENT_OUTPUT_PIN_OE_N_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence s_access;
      PSEL_I && PENABLE_I;
   endsequence
   logic rd_done;
   assign rd_done = PREADY_O && !PWRITE_I;
   ////////////////////////////////////////////////////////////////////////
   chk_one_wait: assert property (s_setup ##1 s_access |-> !PREADY_O ##1 PREADY_O)
      else $error("ready not in second access cycle");
   chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready longer than one cycle");
   chk_upper_zero: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_sw_read: assert property (
      rd_done && PADDR_I == `SRL_OFS_MAIN |-> PRDATA_O[1:0] == 2'b00)
      else $error("pulse bits read nonzero");
   chk_resv_read: assert property (
      rd_done && PADDR_I == `SRL_OFS_SRC |-> !PRDATA_O[5] && !PRDATA_O[1])
      else $error("reserved bits read nonzero");
   chk_err_map: assert property (PREADY_O |-> PSLVERR_O ==
      !(PADDR_I inside {`SRL_OFS_MAIN, `SRL_OFS_SRC, `SRL_OFS_STAT}))
      else $error("error response wrong");
   chk_true_idle: assert property (
      TRUE_OUTPUT_PIN_OE_N_O |-> !TRUE_OUTPUT_PIN_O)
      else $error("true pin active while undriven");
   chk_comp_idle: assert property (
      COMPLEMENT_OUTPUT_PIN_OE_N_O |-> !COMPLEMENT_OUTPUT_PIN_O)
      else $error("complement pin active while undriven");
   chk_both_inverse: assert property (
      !TRUE_OUTPUT_PIN_OE_N_O && !COMPLEMENT_OUTPUT_PIN_OE_N_O
      |-> TRUE_OUTPUT_PIN_O != COMPLEMENT_OUTPUT_PIN_O)
      else $error("pins not complementary");
   chk_disable_pins: assert property (
      PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == `SRL_OFS_MAIN
      && !PWDATA_I[`SRL_B_MOD_EN]
      |-> ##2 TRUE_OUTPUT_PIN_OE_N_O && COMPLEMENT_OUTPUT_PIN_OE_N_O)
      else $error("pins driven after disable");
endmodule : srl_latch_ctrl_checker
`default_nettype wire

// [verif/srl_src_model.sv]
// Far-side model: external input pin and comparator levels
`timescale 1ns/1ns
`default_nettype none
module srl_src_model (
   input wire logic clk_i,
   input wire logic pin_req_i,
   input wire logic cmp_req_i,
   output logic pin_o,
   output logic cmp_o
);
   initial pin_o = 1'b0;
   initial cmp_o = 1'b0;
   // Levels move just after an edge, as an async source would
   always @(posedge clk_i) begin
      pin_o <= pin_req_i;
      cmp_o <= cmp_req_i;
   end
endmodule : srl_src_model
`default_nettype wire

// [verif/tb_srl_latch_ctrl.sv]
// Register-level regression of the latch control block
`timescale 1ns/1ns
`default_nettype none
`include "srl_latch_cfg.svh"
module tb_srl_latch_ctrl;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [3:0] pst = 4'hF;
   logic pin_req = 1'b0;
   logic cmp_req = 1'b0;
   logic pin;
   logic cmp;
   logic [31:0] prd;
   logic rdy;
   logic err;
   logic q;
   logic qoe;
   logic qn;
   logic qnoe;
   logic [31:0] rq;
   logic re;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   // Sources: pin set, comparator set, pin reset, comparator reset
   // Fields: source select, pin level, comparator level, preset, result
   logic [11:0] tbl [8] = '{12'h809, 12'h003, 12'h105, 12'h08A, 12'h016,
      12'h88A, 12'h813, 12'h81C};
   always #5 clk = ~clk;
   srl_src_model src_u (.clk_i(clk), .pin_req_i(pin_req),
      .cmp_req_i(cmp_req), .pin_o(pin), .cmp_o(cmp));
   srl_latch_ctrl dut_u (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
      .PSTRB_I(pst), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
      .EXTERNAL_SETRESET_INPUT_I(pin), .FIRST_COMPARATOR_I(cmp),
      .TRUE_OUTPUT_PIN_O(q), .TRUE_OUTPUT_PIN_OE_N_O(qoe),
      .COMPLEMENT_OUTPUT_PIN_O(qn), .COMPLEMENT_OUTPUT_PIN_OE_N_O(qnoe));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Ready is sampled at the rising edge; the bench timeout ends a hang
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1);
      rq = prd;
      re = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] d,
      input logic e);
      apb(1'b0, a, 32'h0);
      chk({31'h0, re}, {31'h0, e});
      if (!e) chk(rq, {24'h0, d});
   endtask : rd
   task automatic pins(input logic [3:0] e);
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({28'h0, q, qoe, qn, qnoe}, {28'h0, e});
   endtask : pins
   // Waits for the true pin to go low, then high; returns the cycle
   task automatic rise(output int t);
      int n;
      n = 0;
      do @(negedge clk); while (q !== 1'b0 && ++n < 1200);
      do @(negedge clk); while (q !== 1'b1 && ++n < 2400);
      t = cyc;
   endtask : rise
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int t1;
      int t2;
      int nd;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(`SRL_OFS_MAIN, 8'h00, 1'b0);
      rd(`SRL_OFS_SRC, 8'h00, 1'b0);
      rd(12'h00C, 8'h00, 1'b1);
      pst <= 4'hE;
      wr(`SRL_OFS_SRC, 8'hFF);
      pst <= 4'hF;
      rd(`SRL_OFS_SRC, 8'h00, 1'b0);
      wr(`SRL_OFS_SRC, 8'hFF);
      rd(`SRL_OFS_SRC, 8'hDD, 1'b0);
      wr(`SRL_OFS_SRC, 8'h00);
      wr(`SRL_OFS_MAIN, 8'h02);
      wr(`SRL_OFS_MAIN, 8'h8C);
      pins(4'b1000);
      rd(`SRL_OFS_MAIN, 8'h8C, 1'b0);
      wr(`SRL_OFS_MAIN, 8'h8D);
      pins(4'b0010);
      wr(`SRL_OFS_MAIN, 8'h8E);
      pins(4'b1000);
      wr(`SRL_OFS_MAIN, 8'h88);
      pins(4'b1001);
      wr(`SRL_OFS_MAIN, 8'h84);
      pins(4'b0100);
      wr(`SRL_OFS_MAIN, 8'h0C);
      pins(4'b0101);
      $display("test controls done");
      foreach (tbl[i]) begin
         wr(`SRL_OFS_SRC, 8'h00);
         wr(`SRL_OFS_MAIN, tbl[i][1] ? 8'h8E : 8'h8D);
         wr(`SRL_OFS_SRC, tbl[i][11:4]);
         pin_req <= tbl[i][3];
         cmp_req <= tbl[i][2];
         pins({tbl[i][0], 1'b0, !tbl[i][0], 1'b0});
         pin_req <= 1'b0;
         cmp_req <= 1'b0;
      end
      $display("test sources done");
      for (int s = 0; s < 8; s++) begin
         nd = 4 << s;
         wr(`SRL_OFS_SRC, 8'h00);
         wr(`SRL_OFS_MAIN, {1'b1, 3'(s), 4'hD});
         wr(`SRL_OFS_SRC, 8'h40);
         rise(t1);
         wr(`SRL_OFS_MAIN, {1'b1, 3'(s), 4'hD});
         rise(t2);
         chk({31'h0, (t2 - t1) % nd == 0 && t2 - t1 <= 2 * nd}, 32'h1);
      end
      wr(`SRL_OFS_SRC, 8'h00);
      wr(`SRL_OFS_MAIN, 8'h8E);
      wr(`SRL_OFS_SRC, 8'h04);
      pins(4'b0010);
      $display("test divider done");
      complete_run();
   end
endmodule : tb_srl_latch_ctrl
bind srl_latch_ctrl srl_latch_ctrl_checker chk_u (.REF_CLK_I(REF_CLK_I),
   .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .TRUE_OUTPUT_PIN_O(TRUE_OUTPUT_PIN_O),
   .TRUE_OUTPUT_PIN_OE_N_O(TRUE_OUTPUT_PIN_OE_N_O),
   .COMPLEMENT_OUTPUT_PIN_O(COMPLEMENT_OUTPUT_PIN_O),
   .COMPLEMENT_OUTPUT_PIN_OE_N_O(COMPLEMENT_OUTPUT_PIN_OE_N_O));
`default_nettype wire
